// [core/nor_flash_command_decoder.v]
`timescale 1ns/10ps
`include "nor_cmd_defines.vh"

module nor_flash_command_decoder
#(
	parameter ADDR_W = 24,
	parameter BUF_WORDS = 32,
	parameter CNT_W = 6
)
(
	input wire clk_in,
	input wire reset_n_in,
	input wire cmd_valid_in,
	input wire [4:0] cmd_op_in,
	input wire [ADDR_W-1:0] cmd_addr_in,
	input wire [15:0] cmd_data_in,
	input wire [CNT_W-1:0] cmd_count_in,
	output reg cmd_ready_out,
	input wire word_valid_in,
	input wire [ADDR_W-1:0] word_addr_in,
	input wire [15:0] word_data_in,
	output reg word_ready_out,
	output reg rsp_valid_out,
	output reg rsp_error_out,
	output reg [15:0] rsp_data_out,
	output reg bypass_mode_out,
	output wire [ADDR_W-1:0] flash_addr_out,
	output wire [15:0] flash_dq_out,
	output wire flash_dq_oe_out,
	input wire [15:0] flash_dq_in,
	output wire flash_ce_n_out,
	output wire flash_we_n_out,
	output wire flash_oe_n_out
);

	localparam S_IDLE = 2'd0;
	localparam S_ISSUE = 2'd1;
	localparam S_WORD = 2'd2;
	localparam S_BUSY = 2'd3;

	reg [1:0] state_q;
	reg [4:0] op_q;
	reg [2:0] step_q;
	reg [ADDR_W-1:0] addr_q;
	reg [15:0] data_q;
	reg [CNT_W-1:0] count_q;
	reg [CNT_W-1:0] left_q;
	reg start_q;
	reg write_q;
	reg [ADDR_W-1:0] bus_addr_q;
	reg [15:0] bus_data_q;

	wire [2:0] kind;
	wire [11:0] c_addr;
	wire [7:0] c_data;
	wire last;
	wire bus_done;
	wire [15:0] bus_rd;
	// Buffer count limits and the count-minus-one word
	wire [31:0] count_wide = {{(32-CNT_W){1'b0}}, cmd_count_in};
	wire count_ok = (cmd_count_in != {CNT_W{1'b0}}) && (count_wide <= BUF_WORDS);
	wire [CNT_W-1:0] count_m1 = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
	wire finish = (state_q == S_BUSY) && bus_done && last;

	reg autosel_q;
	reg legal;
	reg [ADDR_W-1:0] nxt_addr;
	reg [15:0] nxt_data;

	nor_seq_step nor_seq_step_inst
	(
		.op_in(op_q),
		.step_in(step_q),
		.kind_out(kind),
		.addr_out(c_addr),
		.data_out(c_data),
		.last_out(last)
	);

	nor_bus_cycle #(.ADDR_W(ADDR_W)) nor_bus_cycle_inst
	(
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.start_in(start_q),
		.write_in(write_q),
		.addr_in(bus_addr_q),
		.data_in(bus_data_q),
		.done_out(bus_done),
		.rd_data_out(bus_rd),
		.flash_addr_out(flash_addr_out),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_out(flash_dq_oe_out),
		.flash_dq_in(flash_dq_in),
		.flash_ce_n_out(flash_ce_n_out),
		.flash_we_n_out(flash_we_n_out),
		.flash_oe_n_out(flash_oe_n_out)
	);

	// Only sequences valid in the current mode are started
	always @*
	begin
		legal = 1'b0;
		case (cmd_op_in)
			`OP_READ:
				legal = !autosel_q;
			`OP_RESET, `OP_ABORT, `OP_SUSPEND, `OP_RESUME:
				legal = 1'b1;
			`OP_BYP_PROG, `OP_BYP_SECT, `OP_BYP_CHIP, `OP_BYP_EXIT:
				legal = bypass_mode_out;
			`OP_BUFFER:
				legal = !bypass_mode_out && count_ok;
			`OP_AUTOSEL, `OP_CFI, `OP_PROGRAM, `OP_BYP_ENTER:
				legal = !bypass_mode_out;
			`OP_CHIP_ERASE, `OP_SECT_ERASE, `OP_SEC_ENTRY, `OP_SEC_EXIT:
				legal = !bypass_mode_out;
			default:
				legal = 1'b0;
		endcase
	end

	// Command cycles drive zero on ignored high address bits and upper data byte
	always @*
	begin
		nxt_addr = {{(ADDR_W-12){1'b0}}, c_addr};
		nxt_data = {8'h00, c_data};
		case (kind)
			`K_SA:
				nxt_addr = addr_q;
			`K_USER:
			begin
				nxt_addr = addr_q;
				nxt_data = data_q;
			end
			`K_COUNT:
			begin
				nxt_addr = addr_q;
				nxt_data = {{(16-CNT_W){1'b0}}, count_m1};
			end
			`K_READ:
				nxt_addr = addr_q;
			default:
			begin
				nxt_addr = {{(ADDR_W-12){1'b0}}, c_addr};
				nxt_data = {8'h00, c_data};
			end
		endcase
	end

	always @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			state_q <= S_IDLE;
			op_q <= `OP_READ;
			step_q <= 3'd0;
			addr_q <= {ADDR_W{1'b0}};
			data_q <= 16'h0000;
			count_q <= {CNT_W{1'b0}};
			left_q <= {CNT_W{1'b0}};
			start_q <= 1'b0;
			write_q <= 1'b0;
			bus_addr_q <= {ADDR_W{1'b0}};
			bus_data_q <= 16'h0000;
			cmd_ready_out <= 1'b0;
			word_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_error_out <= 1'b0;
			rsp_data_out <= 16'h0000;
		end
		else
		begin
			rsp_valid_out <= 1'b0;
			start_q <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					cmd_ready_out <= 1'b1;
					if (cmd_valid_in && cmd_ready_out)
					begin
						op_q <= cmd_op_in;
						addr_q <= cmd_addr_in;
						data_q <= cmd_data_in;
						count_q <= cmd_count_in;
						left_q <= cmd_count_in;
						step_q <= 3'd0;
						if (legal)
						begin
							// Every operation is one stored sequence of bus cycles
							cmd_ready_out <= 1'b0;
							state_q <= S_ISSUE;
						end
						else
						begin
							rsp_valid_out <= 1'b1;
							rsp_error_out <= 1'b1;
						end
					end
				end
				S_ISSUE:
				if (kind == `K_WORDS)
				begin
					if (left_q == {CNT_W{1'b0}})
						step_q <= step_q + 3'd1;
					else
					begin
						word_ready_out <= 1'b1;
						state_q <= S_WORD;
					end
				end
				else
				begin
					start_q <= 1'b1;
					write_q <= (kind != `K_READ);
					bus_addr_q <= nxt_addr;
					bus_data_q <= nxt_data;
					state_q <= S_BUSY;
				end
				S_WORD:
				if (word_valid_in)
				begin
					word_ready_out <= 1'b0;
					start_q <= 1'b1;
					write_q <= 1'b1;
					bus_addr_q <= word_addr_in;
					bus_data_q <= word_data_in;
					left_q <= left_q - {{(CNT_W-1){1'b0}}, 1'b1};
					state_q <= S_BUSY;
				end
				S_BUSY:
				if (bus_done)
				begin
					if (last)
					begin
						rsp_valid_out <= 1'b1;
						rsp_error_out <= 1'b0;
						rsp_data_out <= bus_rd;
						state_q <= S_IDLE;
					end
					else
					begin
						if (kind != `K_WORDS)
							step_q <= step_q + 3'd1;
						state_q <= S_ISSUE;
					end
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// Mode flags follow the mode the flash is left in by bypass enter/exit, autoselect and reset only
	always @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			bypass_mode_out <= 1'b0;
			autosel_q <= 1'b0;
		end
		else if (finish)
		begin
			if (op_q == `OP_BYP_ENTER)
				bypass_mode_out <= 1'b1;
			if (op_q == `OP_BYP_EXIT)
				bypass_mode_out <= 1'b0;
			// The flash answers ID words, not array data, until a reset
			if (op_q == `OP_AUTOSEL)
				autosel_q <= 1'b1;
			if (op_q == `OP_RESET)
				autosel_q <= 1'b0;
		end
	end

endmodule

// [core/nor_cmd_defines.vh]
`ifndef NOR_CMD_DEFINES_VH
`define NOR_CMD_DEFINES_VH

// Host clock
`define CLK_NS 25

// Strobe timing in ns and derived cycle counts (least times round up)
`define T_PULSE_NS 35
`define T_HIGH_NS 30
`define T_ACC_NS 100
`define PULSE_CYC ((`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define HIGH_CYC ((`T_HIGH_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define SYNC_CYC 2

// User operation codes
`define OP_READ 5'h00
`define OP_RESET 5'h01
`define OP_AUTOSEL 5'h02
`define OP_CFI 5'h03
`define OP_PROGRAM 5'h04
`define OP_BUFFER 5'h05
`define OP_ABORT 5'h06
`define OP_BYP_ENTER 5'h07
`define OP_BYP_PROG 5'h08
`define OP_BYP_SECT 5'h09
`define OP_BYP_CHIP 5'h0a
`define OP_BYP_EXIT 5'h0b
`define OP_CHIP_ERASE 5'h0c
`define OP_SECT_ERASE 5'h0d
`define OP_SUSPEND 5'h0e
`define OP_RESUME 5'h0f
`define OP_SEC_ENTRY 5'h10
`define OP_SEC_EXIT 5'h11

// Step kinds
`define K_CONST 3'h0
`define K_SA 3'h1
`define K_USER 3'h2
`define K_COUNT 3'h3
`define K_WORDS 3'h4
`define K_READ 3'h5

// Command addresses
`define A_UNL1 12'h555
`define A_UNL2 12'h2aa
`define A_CFI 12'h055
`define A_ZERO 12'h000

// Command data
`define D_UNL1 8'haa
`define D_UNL2 8'h55
`define D_RESET 8'hf0
`define D_AUTOSEL 8'h90
`define D_CFI 8'h98
`define D_PROGRAM 8'ha0
`define D_BUF_LOAD 8'h25
`define D_BUF_CONFIRM 8'h29
`define D_BYPASS 8'h20
`define D_ERASE 8'h80
`define D_SECT 8'h30
`define D_CHIP 8'h10
`define D_EXIT 8'h00
`define D_SUSPEND 8'hb0
`define D_RESUME 8'h30
`define D_SECURED 8'h88

`endif

// [core/nor_seq_step.v]
`timescale 1ns/10ps
`include "nor_cmd_defines.vh"

module nor_seq_step
(
	input wire [4:0] op_in,
	input wire [2:0] step_in,
	output reg [2:0] kind_out,
	output reg [11:0] addr_out,
	output reg [7:0] data_out,
	output reg last_out
);

	reg prefix;
	reg [2:0] s;

	always @*
	begin
		kind_out = `K_CONST;
		addr_out = `A_UNL1;
		data_out = `D_UNL1;
		last_out = 1'b0;
		prefix = (op_in == `OP_AUTOSEL) || (op_in == `OP_PROGRAM) || (op_in == `OP_BUFFER) ||
			(op_in == `OP_ABORT) || (op_in == `OP_BYP_ENTER) || (op_in == `OP_CHIP_ERASE) ||
			(op_in == `OP_SECT_ERASE) || (op_in == `OP_SEC_ENTRY) || (op_in == `OP_SEC_EXIT);
		s = prefix ? step_in - 3'd2 : step_in;
		if (prefix && step_in == 3'd1)
		begin
			addr_out = `A_UNL2;
			data_out = `D_UNL2;
		end
		else if (!(prefix && step_in == 3'd0))
		begin
			case (op_in)
				`OP_READ:
				begin
					kind_out = `K_READ;
					last_out = 1'b1;
				end
				`OP_RESET:
				begin
					data_out = `D_RESET;
					last_out = 1'b1;
				end
				`OP_AUTOSEL:
				begin
					data_out = `D_AUTOSEL;
					if (s == 3'd1)
					begin
						kind_out = `K_READ;
						last_out = 1'b1;
					end
				end
				`OP_CFI:
				begin
					addr_out = `A_CFI;
					data_out = `D_CFI;
					last_out = 1'b1;
				end
				`OP_PROGRAM:
				begin
					data_out = `D_PROGRAM;
					if (s == 3'd1)
					begin
						kind_out = `K_USER;
						last_out = 1'b1;
					end
				end
				`OP_BUFFER:
				begin
					kind_out = (s == 3'd1) ? `K_COUNT : (s == 3'd2) ? `K_WORDS : `K_SA;
					data_out = (s == 3'd3) ? `D_BUF_CONFIRM : `D_BUF_LOAD;
					last_out = (s == 3'd3);
				end
				`OP_ABORT:
				begin
					data_out = `D_RESET;
					last_out = 1'b1;
				end
				`OP_BYP_ENTER:
				begin
					data_out = `D_BYPASS;
					last_out = 1'b1;
				end
				`OP_BYP_PROG:
				begin
					data_out = `D_PROGRAM;
					if (s == 3'd1)
					begin
						kind_out = `K_USER;
						last_out = 1'b1;
					end
				end
				`OP_BYP_SECT, `OP_BYP_CHIP:
				begin
					data_out = `D_ERASE;
					if (s == 3'd1)
					begin
						kind_out = (op_in == `OP_BYP_SECT) ? `K_SA : `K_CONST;
						data_out = (op_in == `OP_BYP_SECT) ? `D_SECT : `D_CHIP;
						last_out = 1'b1;
					end
				end
				`OP_BYP_EXIT:
				begin
					data_out = (s == 3'd1) ? `D_EXIT : `D_AUTOSEL;
					last_out = (s == 3'd1);
				end
				`OP_CHIP_ERASE, `OP_SECT_ERASE:
				begin
					// Erase setup, second unlock pair, then the erase target
					addr_out = (s == 3'd2) ? `A_UNL2 : `A_UNL1;
					data_out = (s == 3'd0) ? `D_ERASE : (s == 3'd1) ? `D_UNL1 : (s == 3'd2) ? `D_UNL2 :
						(op_in == `OP_SECT_ERASE) ? `D_SECT : `D_CHIP;
					if (s == 3'd3)
					begin
						kind_out = (op_in == `OP_SECT_ERASE) ? `K_SA : `K_CONST;
						last_out = 1'b1;
					end
				end
				`OP_SUSPEND:
				begin
					data_out = `D_SUSPEND;
					last_out = 1'b1;
				end
				`OP_RESUME:
				begin
					data_out = `D_RESUME;
					last_out = 1'b1;
				end
				`OP_SEC_ENTRY:
				begin
					data_out = `D_SECURED;
					last_out = 1'b1;
				end
				`OP_SEC_EXIT:
				begin
					addr_out = (s == 3'd1) ? `A_ZERO : `A_UNL1;
					data_out = (s == 3'd1) ? `D_EXIT : `D_AUTOSEL;
					last_out = (s == 3'd1);
				end
				default:
				begin
					data_out = `D_RESET;
					last_out = 1'b1;
				end
			endcase
		end
	end

endmodule

// [core/nor_bus_cycle.v]
`timescale 1ns/10ps
`include "nor_cmd_defines.vh"

module nor_bus_cycle
#(
	parameter ADDR_W = 24
)
(
	input wire clk_in,
	input wire reset_n_in,
	input wire start_in,
	input wire write_in,
	input wire [ADDR_W-1:0] addr_in,
	input wire [15:0] data_in,
	output reg done_out,
	output reg [15:0] rd_data_out,
	output reg [ADDR_W-1:0] flash_addr_out,
	output reg [15:0] flash_dq_out,
	output reg flash_dq_oe_out,
	input wire [15:0] flash_dq_in,
	output reg flash_ce_n_out,
	output reg flash_we_n_out,
	output reg flash_oe_n_out
);

	localparam P_IDLE = 3'd0;
	localparam P_SETUP = 3'd1;
	localparam P_PULSE = 3'd2;
	localparam P_HOLD = 3'd3;
	localparam P_RECOV = 3'd4;
	localparam integer PULSE_LOAD_I = `PULSE_CYC - 1;
	localparam integer READ_LOAD_I = `ACC_CYC + `SYNC_CYC - 1;
	localparam integer RECOV_LOAD_I = `HIGH_CYC - 1;
	localparam [7:0] PULSE_LOAD = PULSE_LOAD_I[7:0];
	localparam [7:0] READ_LOAD = READ_LOAD_I[7:0];
	localparam [7:0] RECOV_LOAD = RECOV_LOAD_I[7:0];

	reg [2:0] phase_q;
	reg [7:0] cnt_q;
	reg wr_q;
	reg [15:0] dq_meta_q;
	reg [15:0] dq_sync_q;

	always @(posedge clk_in)
	begin
		dq_meta_q <= flash_dq_in;
		dq_sync_q <= dq_meta_q;
	end

	always @(posedge clk_in)
	begin
		if (!reset_n_in)
		begin
			phase_q <= P_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			done_out <= 1'b0;
			rd_data_out <= 16'h0000;
			flash_addr_out <= {ADDR_W{1'b0}};
			flash_dq_out <= 16'h0000;
			flash_dq_oe_out <= 1'b0;
			flash_ce_n_out <= 1'b1;
			flash_we_n_out <= 1'b1;
			flash_oe_n_out <= 1'b1;
		end
		else
		begin
			done_out <= 1'b0;
			case (phase_q)
				P_IDLE:
				if (start_in)
				begin
					// Chip select falls first so the write strobe is the later falling edge
					wr_q <= write_in;
					flash_addr_out <= addr_in;
					flash_dq_out <= data_in;
					flash_dq_oe_out <= write_in;
					flash_ce_n_out <= 1'b0;
					phase_q <= P_SETUP;
				end
				P_SETUP:
				begin
					flash_we_n_out <= ~wr_q;
					flash_oe_n_out <= wr_q;
					cnt_q <= wr_q ? PULSE_LOAD : READ_LOAD;
					phase_q <= P_PULSE;
				end
				P_PULSE:
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else
				begin
					// Write strobe rises before chip select, so data latches on it
					flash_we_n_out <= 1'b1;
					flash_oe_n_out <= 1'b1;
					if (!wr_q)
						rd_data_out <= dq_sync_q;
					phase_q <= P_HOLD;
				end
				P_HOLD:
				begin
					flash_ce_n_out <= 1'b1;
					flash_dq_oe_out <= 1'b0;
					cnt_q <= RECOV_LOAD;
					phase_q <= P_RECOV;
				end
				P_RECOV:
				if (cnt_q != 8'h00)
					cnt_q <= cnt_q - 8'h01;
				else
				begin
					done_out <= 1'b1;
					phase_q <= P_IDLE;
				end
				default:
					phase_q <= P_IDLE;
			endcase
		end
	end

endmodule

// [tb/nor_flash_command_decoder_chk.sv]
`timescale 1ns/10ps
`include "nor_cmd_defines.vh"
module nor_flash_command_decoder_chk
#(
	parameter ADDR_W = 24,
	parameter BUF_WORDS = 32,
	parameter CNT_W = 6
)
(
	input wire clk_in,
	input wire reset_n_in,
	input wire cmd_valid_in,
	input wire [4:0] cmd_op_in,
	input wire cmd_ready_out,
	input wire word_valid_in,
	input wire word_ready_out,
	input wire rsp_valid_out,
	input wire rsp_error_out,
	input wire bypass_mode_out,
	input wire [ADDR_W-1:0] flash_addr_out,
	input wire [15:0] flash_dq_out,
	input wire flash_dq_oe_out,
	input wire flash_ce_n_out,
	input wire flash_we_n_out,
	input wire flash_oe_n_out
);
	wire take = cmd_valid_in && cmd_ready_out;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence s_we_pulse;
		!flash_we_n_out [*2] ##1 flash_we_n_out;
	endsequence
	sequence s_refused;
		rsp_valid_out && rsp_error_out;
	endsequence
	property p_we_pulse;
		$fell(flash_we_n_out) |-> !flash_ce_n_out && flash_dq_oe_out ##0 s_we_pulse;
	endproperty
	property p_hold;
		!flash_we_n_out && !$past(flash_we_n_out) |-> $stable(flash_dq_out) && $stable(flash_addr_out);
	endproperty
	property p_latch;
		$rose(flash_we_n_out) |-> !flash_ce_n_out && flash_dq_oe_out;
	endproperty
	property p_bad_op;
		take && cmd_op_in > 5'h11 |=> s_refused ##0 cmd_ready_out;
	endproperty
	property p_no_pins;
		take && cmd_op_in > 5'h11 |=> flash_ce_n_out [*3];
	endproperty
	property p_byp_refuse;
		take && !bypass_mode_out && cmd_op_in >= `OP_BYP_PROG && cmd_op_in <= `OP_BYP_EXIT |=> s_refused;
	endproperty
	property p_reset_cmd;
		take && cmd_op_in == `OP_RESET |=> !cmd_ready_out ##[1:20] rsp_valid_out && !rsp_error_out;
	endproperty
	property p_read_oe;
		$fell(flash_oe_n_out) |-> !flash_ce_n_out && !flash_dq_oe_out && flash_we_n_out;
	endproperty
	property p_word;
		word_valid_in && word_ready_out |=> !word_ready_out ##[1:8] !flash_ce_n_out;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write pulse wrong");
	a_hold: assert property (p_hold) else $error("bus moved in write pulse");
	a_latch: assert property (p_latch) else $error("data not driven at latch");
	a_bad_op: assert property (p_bad_op) else $error("bad op not refused");
	a_no_pins: assert property (p_no_pins) else $error("refused op moved pins");
	a_byp_refuse: assert property (p_byp_refuse) else $error("bypass op taken outside bypass");
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset command late");
	a_read_oe: assert property (p_read_oe) else $error("read strobe wrong");
	a_word: assert property (p_word) else $error("buffer word not written");
endmodule
bind nor_flash_command_decoder nor_flash_command_decoder_chk #(.ADDR_W(ADDR_W), .BUF_WORDS(BUF_WORDS), .CNT_W(CNT_W)) chk_inst
(
	.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
	.cmd_ready_out(cmd_ready_out), .word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
	.rsp_valid_out(rsp_valid_out), .rsp_error_out(rsp_error_out), .bypass_mode_out(bypass_mode_out),
	.flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
	.flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out), .flash_oe_n_out(flash_oe_n_out)
);

// [tb/nor_flash_model.sv]
`timescale 1ns/10ps
module nor_flash_model
#(
	parameter [15:0] MFR_ID = 16'h00a5, // Arbitrary value
	parameter [15:0] DEV_ID = 16'h1b3c, // Arbitrary value
	parameter [15:0] DEV_ID2 = 16'h2d4e, // Arbitrary value
	parameter [15:0] DEV_ID3 = 16'h3f50 // Arbitrary value
)
(
	input wire [23:0] addr_in,
	input wire [15:0] dq_in,
	input wire ce_n_in,
	input wire we_n_in,
	input wire oe_n_in,
	output wire [15:0] dq_out
);
	logic [15:0] mem [0:255];
	logic [39:0] log_q [$];
	logic [23:0] lat_a;
	logic [15:0] held = 16'h0;
	logic [15:0] rd;
	logic autosel = 1'b0;
	logic prog = 1'b0;
	wire wr_n = ce_n_in | we_n_in;
	always @(negedge wr_n) lat_a = addr_in;
	always @(posedge wr_n)
	begin
		log_q.push_back({lat_a, dq_in});
		if (prog)
			mem[lat_a[7:0]] = dq_in;
		prog = dq_in[7:0] == 8'ha0 && !prog;
		if (dq_in[7:0] == 8'hf0 || dq_in[7:0] == 8'h00)
			autosel = 1'b0;
		else if (dq_in[7:0] == 8'h90 && lat_a[11:0] == 12'h555)
			autosel = 1'b1;
	end
	always @*
	begin
		rd = mem[addr_in[7:0]];
		if (autosel)
			case (addr_in[7:0])
				8'h00: rd = MFR_ID;
				8'h01: rd = DEV_ID;
				8'h0e: rd = DEV_ID2;
				8'h0f: rd = DEV_ID3;
				8'h02: rd = 16'h0001;
				8'h03: rd = 16'h0080;
				default: rd = 16'h0;
			endcase
	end
	// Released bus shows the inverse of the last word read
	always @(posedge oe_n_in) held <= rd;
	assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~held;
endmodule

// [tb/tb_nor_flash_command_decoder.sv]
`timescale 1ns/10ps
`include "nor_cmd_defines.vh"
module tb_nor_flash_command_decoder;
	localparam [23:0] X = 24'hffffff;
	logic clk_in = 0, reset_n_in = 0, cmd_valid_in = 0, word_valid_in = 0;
	logic [4:0] cmd_op_in = 0;
	logic [23:0] cmd_addr_in = 0, word_addr_in = 0;
	logic [15:0] cmd_data_in = 0, word_data_in = 0, rdat;
	logic [5:0] cmd_count_in = 0;
	wire cmd_ready_out, word_ready_out, rsp_valid_out, rsp_error_out, bypass_mode_out;
	wire flash_dq_oe_out, flash_ce_n_out, flash_we_n_out, flash_oe_n_out;
	wire [15:0] rsp_data_out, flash_dq_out, mdq;
	wire [23:0] flash_addr_out;
	wire [15:0] flash_dq_in = flash_dq_oe_out ? flash_dq_out : mdq;
	int num_errors = 0, tests_run = 0, cyc = 0;
	logic [39:0] exp_q [$];
	nor_flash_command_decoder nor_flash_command_decoder_inst
	(
		.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
		.cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in), .cmd_count_in(cmd_count_in),
		.cmd_ready_out(cmd_ready_out), .word_valid_in(word_valid_in), .word_addr_in(word_addr_in),
		.word_data_in(word_data_in), .word_ready_out(word_ready_out), .rsp_valid_out(rsp_valid_out),
		.rsp_error_out(rsp_error_out), .rsp_data_out(rsp_data_out), .bypass_mode_out(bypass_mode_out),
		.flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out),
		.flash_dq_in(flash_dq_in), .flash_ce_n_out(flash_ce_n_out), .flash_we_n_out(flash_we_n_out),
		.flash_oe_n_out(flash_oe_n_out)
	);
	nor_flash_model flash_inst
	(
		.addr_in(flash_addr_out), .dq_in(flash_dq_out), .ce_n_in(flash_ce_n_out),
		.we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out), .dq_out(mdq)
	);
	always #12.5 clk_in = ~clk_in;
	task report_and_stop;
		$display("errors %0d comparisons %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			report_and_stop();
		end
	end
	task chk(input logic [39:0] got, input logic [39:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task w(input logic [23:0] a, input logic [15:0] d);
		exp_q.push_back({a, d});
	endtask
	task unl;
		w(24'h555, 16'h00aa);
		w(24'h2aa, 16'h0055);
	endtask
	// Issues one command and compares the bus writes it caused with exp_q
	task cmd(input logic [4:0] op, input logic [23:0] a, input logic [15:0] d, input logic [5:0] n, input logic e);
		int base;
		logic [39:0] g;
		base = flash_inst.log_q.size();
		@(posedge clk_in);
		cmd_op_in <= op;
		cmd_addr_in <= a;
		cmd_data_in <= d;
		cmd_count_in <= n;
		cmd_valid_in <= 1'b1;
		do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
		cmd_valid_in <= 1'b0;
		do @(posedge clk_in); while (rsp_valid_out !== 1'b1);
		rdat = rsp_data_out;
		chk(rsp_error_out, e);
		chk(flash_inst.log_q.size(), base + exp_q.size());
		foreach (exp_q[i])
		begin
			g = flash_inst.log_q[base + i];
			if (exp_q[i][39:16] == X)
				g[39:16] = X;
			chk(g, exp_q[i]);
		end
		exp_q.delete();
	endtask
	task t_read_reset;
		cmd(`OP_READ, 24'h5, 16'h0, 6'h0, 1'b0);
		chk(rdat, 16'h5a5a);
		w(X, 16'h00f0);
		cmd(`OP_RESET, 24'h0, 16'h0, 6'h0, 1'b0);
		cmd(5'h12, 24'h0, 16'h0, 6'h0, 1'b1);
		cmd(`OP_BYP_PROG, 24'h0, 16'h0, 6'h0, 1'b1);
	endtask
	task t_autosel;
		logic [23:0] off [6];
		logic [15:0] id [6];
		off = '{24'h0, 24'h1, 24'he, 24'hf, 24'h10002, 24'h3};
		id = '{flash_inst.MFR_ID, flash_inst.DEV_ID, flash_inst.DEV_ID2, flash_inst.DEV_ID3, 16'h0001, 16'h0080};
		for (int i = 0; i < 6; i++)
		begin
			unl();
			w(24'h555, 16'h0090);
			cmd(`OP_AUTOSEL, off[i], 16'h0, 6'h0, 1'b0);
			chk(rdat, id[i]);
			if (i == 0)
				cmd(`OP_READ, 24'h5, 16'h0, 6'h0, 1'b1);
			w(X, 16'h00f0);
			cmd(`OP_RESET, 24'h0, 16'h0, 6'h0, 1'b0);
		end
	endtask
	task t_program;
		unl();
		w(24'h555, 16'h00a0);
		w(24'h10, 16'h1234);
		cmd(`OP_PROGRAM, 24'h10, 16'h1234, 6'h0, 1'b0);
		cmd(`OP_READ, 24'h10, 16'h0, 6'h0, 1'b0);
		chk(rdat, 16'h1234);
	endtask
	task t_buffer;
		unl();
		w(24'h20100, 16'h0025);
		w(24'h20100, 16'h0001);
		w(24'h20100, 16'hbe01);
		w(24'h20101, 16'hbe02);
		w(24'h20100, 16'h0029);
		fork
			cmd(`OP_BUFFER, 24'h20100, 16'h0, 6'h2, 1'b0);
			for (int k = 0; k < 2; k++)
			begin
				@(posedge clk_in);
				word_valid_in <= 1'b1;
				word_addr_in <= 24'h20100 + k;
				word_data_in <= 16'hbe01 + k;
				do @(posedge clk_in); while (word_ready_out !== 1'b1);
				word_valid_in <= 1'b0;
			end
		join
		cmd(`OP_BUFFER, 24'h20100, 16'h0, 6'h0, 1'b1);
		cmd(`OP_BUFFER, 24'h20100, 16'h0, 6'h21, 1'b1);
	endtask
	task t_sequences;
		unl();
		w(24'h555, 16'h00f0);
		cmd(`OP_ABORT, 24'h0, 16'h0, 6'h0, 1'b0);
		w(24'h055, 16'h0098);
		cmd(`OP_CFI, 24'h0, 16'h0, 6'h0, 1'b0);
		unl();
		w(24'h555, 16'h0080);
		unl();
		w(24'h555, 16'h0010);
		cmd(`OP_CHIP_ERASE, 24'h0, 16'h0, 6'h0, 1'b0);
		unl();
		w(24'h555, 16'h0080);
		unl();
		w(24'h30000, 16'h0030);
		cmd(`OP_SECT_ERASE, 24'h30000, 16'h0, 6'h0, 1'b0);
		w(X, 16'h00b0);
		cmd(`OP_SUSPEND, 24'h0, 16'h0, 6'h0, 1'b0);
		w(X, 16'h0030);
		cmd(`OP_RESUME, 24'h0, 16'h0, 6'h0, 1'b0);
		unl();
		w(24'h555, 16'h0088);
		cmd(`OP_SEC_ENTRY, 24'h0, 16'h0, 6'h0, 1'b0);
		unl();
		w(24'h555, 16'h0090);
		w(X, 16'h0000);
		cmd(`OP_SEC_EXIT, 24'h0, 16'h0, 6'h0, 1'b0);
	endtask
	task t_bypass;
		unl();
		w(24'h555, 16'h0020);
		cmd(`OP_BYP_ENTER, 24'h0, 16'h0, 6'h0, 1'b0);
		chk(bypass_mode_out, 1'b1);
		cmd(`OP_PROGRAM, 24'h11, 16'h0, 6'h0, 1'b1);
		w(X, 16'h00a0);
		w(24'h11, 16'h4321);
		cmd(`OP_BYP_PROG, 24'h11, 16'h4321, 6'h0, 1'b0);
		w(X, 16'h0080);
		w(24'h30000, 16'h0030);
		cmd(`OP_BYP_SECT, 24'h30000, 16'h0, 6'h0, 1'b0);
		w(X, 16'h0080);
		w(X, 16'h0010);
		cmd(`OP_BYP_CHIP, 24'h0, 16'h0, 6'h0, 1'b0);
		w(X, 16'h0090);
		w(X, 16'h0000);
		cmd(`OP_BYP_EXIT, 24'h0, 16'h0, 6'h0, 1'b0);
		chk(bypass_mode_out, 1'b0);
		cmd(`OP_READ, 24'h11, 16'h0, 6'h0, 1'b0);
		chk(rdat, 16'h4321);
	endtask
	initial
	begin
		flash_inst.mem[5] = 16'h5a5a;
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_read_reset();
		t_autosel();
		t_program();
		t_buffer();
		t_sequences();
		t_bypass();
		report_and_stop();
	end
endmodule
